// [src/gpio_ports_pkg.sv]
package gpio_ports_pkg;

  // number of ports and the widest port
  localparam int NUM_PORTS = 7;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register offsets (byte addresses, one word per port in each bank)
  localparam logic [ADDR_W-1:0] OFS_LATCH_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DIR_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PULLUP_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_CFG = 8'h60;
  localparam logic [ADDR_W-1:0] OFS_CHAN_SEL = 8'h64;
  // last word of a bank is port six; 1C must stay a hole, there is no port seven
  localparam logic [ADDR_W-1:0] BANK_SPAN = 8'h18;

  // which port is shared with the converter
  localparam int ANALOG_PORT = 2;
  localparam int CHAN_W = 3;

  // reset values
  localparam logic [PORT_W-1:0] DIR_RESET = 8'hFF;
  localparam logic [PORT_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [PORT_W-1:0] PULLUP_RESET = 8'h00;
  localparam logic [PORT_W-1:0] ANALOG_CFG_RESET = 8'h00;
  localparam logic [CHAN_W-1:0] CHAN_SEL_RESET = 3'h0;

  // implemented pins per port (port 0 has 7, port 3 has 4)
  localparam logic [NUM_PORTS-1:0][PORT_W-1:0] PIN_MASK = {
    8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h7F
  };
  // pins that offer a pull-up select (none on port 2, upper half of port 6)
  localparam logic [NUM_PORTS-1:0][PORT_W-1:0] PULLUP_MASK = {
    8'hF0, 8'hFF, 8'hFF, 8'h0F, 8'h00, 8'hFF, 8'h7F
  };
  // open-drain pins (lower half of port 6)
  localparam logic [NUM_PORTS-1:0][PORT_W-1:0] OPEN_DRAIN_MASK = {
    8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // drive bundle of one port towards its pads
  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
    logic [PORT_W-1:0] pu;
  } pin_drive_t;

  // axi4-lite master to slave
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;

  // axi4-lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

endpackage

// [src/gpio_pin_cell.sv]
`timescale 1ns/100ps
// one port: pad synchroniser, drive logic and read-back selector
module gpio_pin_cell #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] PIN_MASK = 8'hFF,
  parameter logic [WIDTH-1:0] PULLUP_MASK = 8'hFF,
  parameter logic [WIDTH-1:0] OPEN_DRAIN_MASK = 8'h00
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_latch,
  input wire logic [WIDTH-1:0] i_dir,
  input wire logic [WIDTH-1:0] i_pullup_sel,
  input wire logic [WIDTH-1:0] i_digital,
  input wire logic [WIDTH-1:0] i_alt_en,
  input wire logic [WIDTH-1:0] i_alt_out,
  input wire logic [WIDTH-1:0] i_pad_in,
  output logic [WIDTH-1:0] o_pad_out,
  output logic [WIDTH-1:0] o_pad_oe,
  output logic [WIDTH-1:0] o_pad_pu,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_readback
);

  logic [WIDTH-1:0] meta_q;   // first stage, read only by sync_q
  logic [WIDTH-1:0] sync_q;   // settled pad level
  logic [WIDTH-1:0] value;    // latch or peripheral value
  logic [WIDTH-1:0] out_mode; // pins driving in digital output mode

  ////////////////////////////////////////////////////////////////////////////
  // pad input synchroniser
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_pad_in;
      sync_q <= meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive selection
  // peripheral replaces the latch where it owns the pin
  assign value = (i_alt_en & i_alt_out) | (~i_alt_en & i_latch);
  // direction bit low means output; analog pins never drive
  assign out_mode = ~i_dir & i_digital & PIN_MASK;

  // pad drivers are registered so the pads see no decode glitches
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pad_out <= '0;
      o_pad_oe <= '0;
      o_pad_pu <= '0;
    end else begin
      // open-drain pins only pull low and release instead of driving high
      o_pad_out <= value & ~OPEN_DRAIN_MASK;
      o_pad_oe <= out_mode & (~OPEN_DRAIN_MASK | ~value);
      // pull-up only while the pin is an input
      o_pad_pu <= i_pullup_sel & i_dir & i_digital & PULLUP_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-back: pad level for inputs, latch for outputs, zero for analog
  assign o_readback = PIN_MASK & i_digital & ((i_dir & sync_q) | (~i_dir & i_latch));
  // pin level also goes to the peripheral, whatever drives it
  assign o_level = sync_q & PIN_MASK;

endmodule

// [src/gpio_ports.sv]
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Notes on behaviour
// - port zero: seven pins, per-bit direction
// - port-zero pull-up only in input mode
// - reset puts ports into input mode
// - port one: eight pins, input-only pull-ups
// - port two: eight pins, analog shared, no pull-ups
// - port two digital only when configured digital
// - analog converted when selected; analog output prohibited
// - reset makes port two all analog
// - port three: four pins, input-only pull-ups
// - ports four, five: eight pins, input pull-ups
// - port six pull-ups on upper four only
// - port six lower pins are open drain
// - reset loads direction registers all ones
module gpio_ports (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire gpio_ports_pkg::axil_req_t i_axil,
  output gpio_ports_pkg::axil_rsp_t o_axil,
  input wire logic [6:0][7:0] i_pad_in,
  output gpio_ports_pkg::pin_drive_t [6:0] o_pad,
  input wire logic [6:0][7:0] i_alt_en,
  input wire logic [6:0][7:0] i_alt_out,
  output logic [6:0][7:0] o_alt_in,
  output logic [2:0] o_conv_chan,
  output logic o_conv_chan_ok
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  localparam int NP = gpio_ports_pkg::NUM_PORTS;
  localparam int PW = gpio_ports_pkg::PORT_W;
  localparam int AW = gpio_ports_pkg::ADDR_W;
  localparam int DW = gpio_ports_pkg::DATA_W;
  localparam int AP = gpio_ports_pkg::ANALOG_PORT;

  logic [NP-1:0][PW-1:0] latch_q;  // output latches
  logic [NP-1:0][PW-1:0] dir_q;    // direction, one means input
  logic [NP-1:0][PW-1:0] pullup_q; // pull-up selects
  logic [PW-1:0] analog_pin_config_q; // one means digital i/o
  logic [gpio_ports_pkg::CHAN_W-1:0] converter_channel_select_q;

  logic [NP-1:0][PW-1:0] digital;   // per-pin digital enable
  logic [NP-1:0][PW-1:0] readback;  // per-port read value
  logic [NP-1:0][PW-1:0] level;     // synchronised pad levels

  // write channel holding state
  logic aw_held_q;
  logic w_held_q;
  logic [AW-1:0] waddr_q;
  logic [DW-1:0] wdata_q;
  logic wlane0_q;
  logic do_write;

  // response registers
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [DW-1:0] rdata_q;
  logic [1:0] rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // address decode helpers
  // true when addr is an aligned word inside a seven-port bank
  function automatic logic in_bank(input logic [AW-1:0] addr, input logic [AW-1:0] base);
    in_bank = (addr >= base) && (addr <= base + gpio_ports_pkg::BANK_SPAN)
              && (addr[1:0] == 2'h0);
  endfunction

  // port number of an address inside a bank
  function automatic int bank_port(input logic [AW-1:0] addr, input logic [AW-1:0] base);
    logic [AW-1:0] diff;
    diff = addr - base;
    bank_port = int'(diff[AW-1:2]);
  endfunction

  // true for any address that holds a register
  function automatic logic is_mapped(input logic [AW-1:0] addr);
    is_mapped = in_bank(addr, gpio_ports_pkg::OFS_LATCH_BASE)
                || in_bank(addr, gpio_ports_pkg::OFS_DIR_BASE)
                || in_bank(addr, gpio_ports_pkg::OFS_PULLUP_BASE)
                || (addr == gpio_ports_pkg::OFS_ANALOG_CFG)
                || (addr == gpio_ports_pkg::OFS_CHAN_SEL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // write address and data capture; either may come first
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held_q <= 1'b0;
      waddr_q <= '0;
      awready_q <= 1'b1;
    end else if (i_axil.awvalid && awready_q) begin
      aw_held_q <= 1'b1;
      waddr_q <= i_axil.awaddr;
      awready_q <= 1'b0;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end else if (bvalid_q && i_axil.bready) begin
      // reopen only after the response, so one write is under way at a time
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wlane0_q <= 1'b0;
      wready_q <= 1'b1;
    end else if (i_axil.wvalid && wready_q) begin
      w_held_q <= 1'b1;
      wdata_q <= i_axil.wdata;
      wlane0_q <= i_axil.wstrb[0];
      wready_q <= 1'b0;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end else if (bvalid_q && i_axil.bready) begin
      wready_q <= 1'b1;
    end
  end

  // write commits once both halves are held
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  ////////////////////////////////////////////////////////////////////////////
  // write response
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= gpio_ports_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= is_mapped(waddr_q) ? gpio_ports_pkg::RESP_OKAY : gpio_ports_pkg::RESP_SLVERR;
    end else if (bvalid_q && i_axil.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output latches; only byte lane 0 carries register data
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_q <= {NP{gpio_ports_pkg::LATCH_RESET}};
    end else if (do_write && wlane0_q && in_bank(waddr_q, gpio_ports_pkg::OFS_LATCH_BASE)) begin
      latch_q[bank_port(waddr_q, gpio_ports_pkg::OFS_LATCH_BASE)] <=
        wdata_q[PW-1:0] & gpio_ports_pkg::PIN_MASK[bank_port(waddr_q,
        gpio_ports_pkg::OFS_LATCH_BASE)];
    end
  end

  // direction registers: reset to all ones puts every pin in input mode;
  // missing pins stay fixed at one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_q <= {NP{gpio_ports_pkg::DIR_RESET}};
    end else if (do_write && wlane0_q && in_bank(waddr_q, gpio_ports_pkg::OFS_DIR_BASE)) begin
      dir_q[bank_port(waddr_q, gpio_ports_pkg::OFS_DIR_BASE)] <=
        wdata_q[PW-1:0] | ~gpio_ports_pkg::PIN_MASK[bank_port(waddr_q,
        gpio_ports_pkg::OFS_DIR_BASE)];
    end
  end

  // pull-up selects; bits without a resistor read as zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pullup_q <= {NP{gpio_ports_pkg::PULLUP_RESET}};
    end else if (do_write && wlane0_q && in_bank(waddr_q, gpio_ports_pkg::OFS_PULLUP_BASE)) begin
      pullup_q[bank_port(waddr_q, gpio_ports_pkg::OFS_PULLUP_BASE)] <=
        wdata_q[PW-1:0] & gpio_ports_pkg::PULLUP_MASK[bank_port(waddr_q,
        gpio_ports_pkg::OFS_PULLUP_BASE)];
    end
  end

  // converter pin configuration: reset leaves every shared pin analog
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      analog_pin_config_q <= gpio_ports_pkg::ANALOG_CFG_RESET;
    end else if (do_write && wlane0_q && (waddr_q == gpio_ports_pkg::OFS_ANALOG_CFG)) begin
      analog_pin_config_q <= wdata_q[PW-1:0];
    end
  end

  // converter channel select
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      converter_channel_select_q <= gpio_ports_pkg::CHAN_SEL_RESET;
    end else if (do_write && wlane0_q && (waddr_q == gpio_ports_pkg::OFS_CHAN_SEL)) begin
      converter_channel_select_q <= wdata_q[gpio_ports_pkg::CHAN_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel; answer one cycle after the address is taken
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= gpio_ports_pkg::RESP_OKAY;
    end else if (i_axil.arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= is_mapped(i_axil.araddr) ? gpio_ports_pkg::RESP_OKAY
                                          : gpio_ports_pkg::RESP_SLVERR;
      rdata_q <= '0;
      if (in_bank(i_axil.araddr, gpio_ports_pkg::OFS_LATCH_BASE)) begin
        // port read mixes pad level and latch per direction
        rdata_q[PW-1:0] <= readback[bank_port(i_axil.araddr,
          gpio_ports_pkg::OFS_LATCH_BASE)];
      end else if (in_bank(i_axil.araddr, gpio_ports_pkg::OFS_DIR_BASE)) begin
        rdata_q[PW-1:0] <= dir_q[bank_port(i_axil.araddr, gpio_ports_pkg::OFS_DIR_BASE)];
      end else if (in_bank(i_axil.araddr, gpio_ports_pkg::OFS_PULLUP_BASE)) begin
        rdata_q[PW-1:0] <= pullup_q[bank_port(i_axil.araddr,
          gpio_ports_pkg::OFS_PULLUP_BASE)];
      end else if (i_axil.araddr == gpio_ports_pkg::OFS_ANALOG_CFG) begin
        rdata_q[PW-1:0] <= analog_pin_config_q;
      end else if (i_axil.araddr == gpio_ports_pkg::OFS_CHAN_SEL) begin
        rdata_q[gpio_ports_pkg::CHAN_W-1:0] <= converter_channel_select_q;
      end else begin
        // unmapped: zero data with an error response
        rdata_q <= '0;
      end
    end else if (rvalid_q && i_axil.rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  always_comb begin
    o_axil.awready = awready_q;
    o_axil.wready = wready_q;
    o_axil.bvalid = bvalid_q;
    o_axil.bresp = bresp_q;
    o_axil.arready = arready_q;
    o_axil.rvalid = rvalid_q;
    o_axil.rdata = rdata_q;
    o_axil.rresp = rresp_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin cells, one per port; only the shared port can be analog
  generate
    for (genvar p = 0; p < NP; p++) begin : g_port
      if (p == AP) begin : g_shared
        assign digital[p] = analog_pin_config_q;
      end else begin : g_plain
        assign digital[p] = {PW{1'b1}};
      end

      gpio_pin_cell #(
        .WIDTH(PW),
        .PIN_MASK(gpio_ports_pkg::PIN_MASK[p]),
        .PULLUP_MASK(gpio_ports_pkg::PULLUP_MASK[p]),
        .OPEN_DRAIN_MASK(gpio_ports_pkg::OPEN_DRAIN_MASK[p])
      ) u_cell (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_latch(latch_q[p]),
        .i_dir(dir_q[p]),
        .i_pullup_sel(pullup_q[p]),
        .i_digital(digital[p]),
        .i_alt_en(i_alt_en[p]),
        .i_alt_out(i_alt_out[p]),
        .i_pad_in(i_pad_in[p]),
        .o_pad_out(o_pad[p].out),
        .o_pad_oe(o_pad[p].oe),
        .o_pad_pu(o_pad[p].pu),
        .o_level(level[p]),
        .o_readback(readback[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pad levels towards the peripherals, registered once more
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_alt_in <= '0;
    end else begin
      o_alt_in <= level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter channel: valid only for an analog pin in input mode;
  // analog with output mode is not blocked, software must avoid it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_conv_chan <= gpio_ports_pkg::CHAN_SEL_RESET;
      o_conv_chan_ok <= 1'b0;
    end else begin
      o_conv_chan <= converter_channel_select_q;
      o_conv_chan_ok <= !analog_pin_config_q[converter_channel_select_q]
                        && dir_q[AP][converter_channel_select_q];
    end
  end

endmodule

// [verification/gpio_ports_sva.sv]
`timescale 1ns/100ps
// watches the port block from its bus, pad, peripheral and converter pins only
module gpio_ports_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire gpio_ports_pkg::axil_req_t i_axil,
  input wire gpio_ports_pkg::axil_rsp_t o_axil,
  input wire logic [6:0][7:0] i_pad_in,
  input wire gpio_ports_pkg::pin_drive_t [6:0] o_pad,
  input wire logic [6:0][7:0] i_alt_en,
  input wire logic [6:0][7:0] i_alt_out,
  input wire logic [6:0][7:0] o_alt_in,
  input wire logic [2:0] o_conv_chan,
  input wire logic o_conv_chan_ok
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic [2:0] age_q; // edges since reset, saturating
  logic [6:0] pu_drv, pu_bad, oe_bad; // per-port misuse flags
  logic oe_on; // any pin driven
  ////////////////////////////////////////////////////////////////
  // age counter: history checks must not see reset-era samples
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  // misuse flags gathered per port
  always_comb begin
    oe_on = 1'b0;
    for (int p = 0; p < 7; p++) begin
      pu_drv[p] = |(o_pad[p].pu & o_pad[p].oe);
      pu_bad[p] = |(o_pad[p].pu & ~gpio_ports_pkg::PULLUP_MASK[p]);
      oe_bad[p] = |(o_pad[p].oe & ~gpio_ports_pkg::PIN_MASK[p]);
      oe_on = oe_on | (|o_pad[p].oe);
    end
  end
  ////////////////////////////////////////////////////////////////
  a_pu_input_only: assert property (pu_drv == 7'h00)
    else $error("pull-up on a driven pin");
  a_pu_where_fitted: assert property (pu_bad == 7'h00)
    else $error("pull-up on a pin without one");
  a_pins_fitted: assert property (oe_bad == 7'h00)
    else $error("drive on a missing pin");
  a_open_drain_low: assert property ((o_pad[6].out & 8'h0F) == 8'h00)
    else $error("open-drain pin driven high");
  a_reset_inputs: assert property ($rose(i_rst_n) |-> !oe_on ##1 !oe_on)
    else $error("pin driven right after reset");
  a_reset_analog: assert property ($rose(i_rst_n) |=> o_conv_chan_ok)
    else $error("channel zero not analog input after reset");
  a_alt_in_follow: assert property (age_q >= 3'h4 |->
    (o_alt_in & gpio_ports_pkg::PIN_MASK) == ($past(i_pad_in, 3) & gpio_ports_pkg::PIN_MASK))
    else $error("peripheral pin level lags wrongly");
  // commit takes one edge after both halves are held, bvalid rises on that same edge
  a_write_answer: assert property (i_axil.awvalid && o_axil.awready &&
    i_axil.wvalid && o_axil.wready |-> ##2 o_axil.bvalid)
    else $error("write response late");
  a_read_answer: assert property (i_axil.arvalid && o_axil.arready |=> o_axil.rvalid)
    else $error("read response late");
endmodule
bind gpio_ports gpio_ports_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_axil(i_axil),
  .o_axil(o_axil), .i_pad_in(i_pad_in), .o_pad(o_pad), .i_alt_en(i_alt_en),
  .i_alt_out(i_alt_out), .o_alt_in(o_alt_in), .o_conv_chan(o_conv_chan),
  .o_conv_chan_ok(o_conv_chan_ok));

// [verification/pad_board_model.sv]
`timescale 1ns/100ps
// board at the pins: chip drive wins, then the outside source, then the pull-up
module pad_board_model (
  input wire logic i_clk,
  input wire gpio_ports_pkg::pin_drive_t [6:0] i_pad,
  input wire logic [6:0][7:0] i_ext_val,
  input wire logic [6:0][7:0] i_ext_en,
  output logic [6:0][7:0] o_level
);
  logic [7:0] float_q = 8'h55; // a floating pin wanders, never keeps its last level
  ////////////////////////////////////////////////////////////////
  // wander pattern for undriven, unpulled pins
  always @(posedge i_clk) begin
    float_q <= ~float_q;
  end
  // open-drain low or release falls out of oe alone
  always_comb begin
    for (int p = 0; p < 7; p++) begin
      o_level[p] = (i_pad[p].oe & i_pad[p].out)
        | (~i_pad[p].oe & i_ext_en[p] & i_ext_val[p])
        | (~i_pad[p].oe & ~i_ext_en[p] & (i_pad[p].pu | float_q));
    end
  end
endmodule

// [verification/tb_top.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  localparam logic [1:0] OK = gpio_ports_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = gpio_ports_pkg::RESP_SLVERR;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  gpio_ports_pkg::axil_req_t req = '0; // bus master drive
  gpio_ports_pkg::axil_rsp_t rsp;
  gpio_ports_pkg::pin_drive_t [6:0] pad;
  logic [6:0][7:0] pad_in, alt_in, alt_en = '0, alt_out = '0, ext_val = '0, ext_en = '1;
  logic [2:0] chan;
  logic chan_ok;
  int miscompares = 0;
  int n_checks = 0;
  logic [31:0] rng = 32'h00010ED8; // xorshift state, seeded with 69336
  logic [33:0] exp_r[$]; // notes of pending reads: resp, data
  logic [1:0] exp_b[$]; // notes of pending writes: resp
  ////////////////////////////////////////////////////////////////
  always begin
    #25 i_clk = ~i_clk;
  end
  gpio_ports u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_axil(req), .o_axil(rsp),
    .i_pad_in(pad_in), .o_pad(pad), .i_alt_en(alt_en), .i_alt_out(alt_out),
    .o_alt_in(alt_in), .o_conv_chan(chan), .o_conv_chan_ok(chan_ok));
  pad_board_model u_board (.i_clk(i_clk), .i_pad(pad), .i_ext_val(ext_val),
    .i_ext_en(ext_en), .o_level(pad_in));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // answers are matched to the oldest note at the handshake edge
  always @(posedge i_clk) begin
    if (rsp.rvalid && req.rready) begin
      `CHK("rdata", exp_r[0][31:0], rsp.rdata)
      `CHK("rresp", exp_r[0][33:32], rsp.rresp)
      void'(exp_r.pop_front());
    end
    if (rsp.bvalid && req.bready) begin
      `CHK("bresp", exp_b[0], rsp.bresp)
      void'(exp_b.pop_front());
    end
  end
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] e);
    exp_b.push_back(e);
    @(posedge i_clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= s;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    // no cycle limit here: only the watchdog may end a wait
    do begin
      @(posedge i_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
  endtask
  // read: rready held until the answer is seen
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    exp_r.push_back({r, e});
    @(posedge i_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
  endtask
  // one port with random latch, direction, pull-ups, peripheral use and outside levels
  task automatic port_chk(input int p, input logic [7:0] cfg);
    logic [7:0] l, d, u, ae, ao, ev, v, oe, pm, od, dg;
    l = 8'(rnd());
    d = 8'(rnd());
    u = 8'(rnd());
    ae = 8'(rnd());
    ao = 8'(rnd());
    ev = 8'(rnd());
    // serial channels stay at defaults, so no peripheral claims their pins
    if (p == 0) ae = ae & 8'hEB;
    if (p == 1) ae = ae & 8'hFA;
    // port-six pin two carries plain levels, never the outside serial clock
    if (p == 6) ae[2] = 1'b0;
    pm = gpio_ports_pkg::PIN_MASK[p];
    od = gpio_ports_pkg::OPEN_DRAIN_MASK[p];
    dg = (p == 2) ? cfg : 8'hFF;
    if (p == 2) d = d | ~cfg;
    @(posedge i_clk);
    alt_en[p] <= ae;
    alt_out[p] <= ao;
    ext_val[p] <= ev;
    wr(8'(4 * p), {24'h0, l}, 4'hF, OK);
    wr(gpio_ports_pkg::OFS_PULLUP_BASE + 8'(4 * p), {24'h0, u}, 4'hF, OK);
    wr(gpio_ports_pkg::OFS_DIR_BASE + 8'(4 * p), {24'h0, d}, 4'hF, OK);
    repeat (4) @(posedge i_clk);
    v = (ae & ao) | (~ae & l);
    oe = ~d & pm & dg & (~od | ~v);
    `CHK("oe", oe, pad[p].oe)
    `CHK("out", oe & v & ~od, pad[p].out & oe)
    `CHK("pu", u & d & dg & gpio_ports_pkg::PULLUP_MASK[p], pad[p].pu)
    `CHK("alt_in", ((oe & v & ~od) | (~oe & ev)) & pm, alt_in[p] & pm)
    rd(8'(4 * p), {24'h0, ((d & ev) | (~d & l)) & pm & dg}, OK);
    rd(gpio_ports_pkg::OFS_DIR_BASE + 8'(4 * p), {24'h0, d | ~pm}, OK);
    rd(gpio_ports_pkg::OFS_PULLUP_BASE + 8'(4 * p),
      {24'h0, u & gpio_ports_pkg::PULLUP_MASK[p]}, OK);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    fork
      begin
        #(50 * 20000);
        miscompares++;
        conclude();
      end
    join_none
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    `CHK("conv_ok", 1'b1, chan_ok)
    for (int p = 0; p < 7; p++) begin
      `CHK("oe_rst", 8'h00, pad[p].oe)
      rd(gpio_ports_pkg::OFS_DIR_BASE + 8'(4 * p), 32'hFF, OK);
      rd(gpio_ports_pkg::OFS_PULLUP_BASE + 8'(4 * p), 32'h0, OK);
    end
    rd(gpio_ports_pkg::OFS_ANALOG_CFG, 32'h0, OK);
    $display("test reset values done");
    // digital use is granted from the lowest pin up, as software must
    wr(gpio_ports_pkg::OFS_ANALOG_CFG, 32'h0F, 4'hF, OK);
    for (int r = 0; r < 3; r++) begin
      for (int p = 0; p < 7; p++) port_chk(p, 8'h0F);
    end
    wr(gpio_ports_pkg::OFS_ANALOG_CFG, 32'hFF, 4'hF, OK);
    repeat (3) port_chk(2, 8'hFF);
    $display("test port pins done");
    wr(gpio_ports_pkg::OFS_ANALOG_CFG, 32'h0F, 4'hF, OK);
    wr(gpio_ports_pkg::OFS_DIR_BASE + 8'h08, 32'hFC, 4'hF, OK);
    for (int c = 0; c < 8; c++) begin
      wr(gpio_ports_pkg::OFS_CHAN_SEL, 32'(c), 4'hF, OK);
      repeat (2) @(posedge i_clk);
      `CHK("chan", 3'(c), chan)
      `CHK("chan_ok", c >= 4, chan_ok)
    end
    $display("test converter select done");
    wr(8'h80, 32'h1, 4'hF, ERR);
    rd(8'h80, 32'h0, ERR);
    // the word just past port six in a bank is a hole as well
    wr(8'h1C, 32'h1, 4'hF, ERR);
    rd(8'h1C, 32'h0, ERR);
    wr(gpio_ports_pkg::OFS_DIR_BASE, 32'hFFFFFF00, 4'hF, OK);
    rd(gpio_ports_pkg::OFS_DIR_BASE, 32'h80, OK);
    wr(gpio_ports_pkg::OFS_LATCH_BASE, 32'h55, 4'hF, OK);
    wr(gpio_ports_pkg::OFS_LATCH_BASE, 32'h2A, 4'h0, OK);
    rd(gpio_ports_pkg::OFS_LATCH_BASE, 32'h55, OK);
    wr(gpio_ports_pkg::OFS_PULLUP_BASE + 8'h08, 32'hFF, 4'hF, OK);
    rd(gpio_ports_pkg::OFS_PULLUP_BASE + 8'h08, 32'h0, OK);
    $display("test refusals done");
    // outside source released: only the pull-up holds the pins up
    wr(gpio_ports_pkg::OFS_DIR_BASE + 8'h14, 32'hFF, 4'hF, OK);
    wr(gpio_ports_pkg::OFS_PULLUP_BASE + 8'h14, 32'hFF, 4'hF, OK);
    ext_en[5] <= 8'h00;
    repeat (4) @(posedge i_clk);
    rd(gpio_ports_pkg::OFS_LATCH_BASE + 8'h14, 32'hFF, OK);
    ext_en[5] <= 8'hFF;
    $display("test pull-up level done");
    wr(gpio_ports_pkg::OFS_DIR_BASE + 8'h10, 32'h00, 4'hF, OK);
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    `CHK("oe_mid_rst", 8'h00, pad[4].oe)
    i_rst_n <= 1'b1;
    rd(gpio_ports_pkg::OFS_DIR_BASE + 8'h10, 32'hFF, OK);
    rd(gpio_ports_pkg::OFS_ANALOG_CFG, 32'h0, OK);
    $display("test second reset done");
    conclude();
  end
endmodule
